// *** core/uart_consts.svh ***
// Offsets, field positions, reset values and timing counts of the serial port.
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define OFS_DATA      3'h0
`define OFS_IEN       3'h1
`define OFS_IID       3'h2
`define OFS_LCTL      3'h3
`define OFS_MCTL      3'h4
`define OFS_LSTAT     3'h5
`define OFS_MSTAT     3'h6
`define OFS_SCRATCH   3'h7
`define LCTL_DLAB     7
`define FCTL_EN       0
`define FCTL_RXCLR    1
`define FCTL_TXCLR    2
`define IEN_RDA       0
`define IEN_THRE      1
`define IEN_LS        2
`define IEN_MS        3
`define MS_CTS        4
`define MS_DSR        5
`define MS_DCD        7
`define IID_NONE      4'h1
`define IID_LS        4'h6
`define IID_RDA       4'h4
`define IID_THRE      4'h2
`define IID_MS        4'h0
`define DIV_RST       16'h0001
`define OVS_LAST      4'hF
`define OVS_MID       4'h7
`define FIFO_DEPTH    16
`define ERR_BITS      3
`endif

// *** core/uart_pkg.sv ***
// Types shared by the serial port design.
package uart_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } tx_state_t;
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
  } modem_in_t;
  typedef struct packed {
    logic       cs_a;
    logic       cs_b;
    logic       cs_c_n;
    logic [2:0] addr;
  } sel_t;
  typedef struct packed {
    logic [2:0] err;
    logic [7:0] data;
  } rx_entry_t;
endpackage

// *** core/uart_fifo_host_modem_port.sv ***
// Serial port with host register pins, optional FIFOs, baud generator and modem status.
//
// Operation
// - Starts in character mode, FIFO mode software selectable.
// - FIFO mode buffers 16 bytes, rx keeps errors.
// - Ready outputs usable as DMA transfer requests.
// - Deserialize serial input, serialize CPU bytes out.
// - CPU can read status at any time.
// - Baud divisor 1..65535 makes 16x transmit clock.
// - 16x clock driven out for the receiver.
// - Strobe low passes selects, high holds them.
// - Respond only when chip selects all active.
// - Data bus driven only during reads.
// - Status bit 4 CTS, bit 0 its change.
// - Status bit 7 DCD, bit 3 its change.
// - Driver disable high unless CPU is reading.
// - Status bit 5 DSR, bit 1 its change.
// - Interrupt on errors, data, empty, modem change.
`include "uart_consts.svh"
module uart_fifo_host_modem_port #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [2:0]         reg_select_i,
  input  wire logic               addr_strobe_n_i,
  input  wire logic               chip_sel_a_i,
  input  wire logic               chip_sel_b_i,
  input  wire logic               chip_sel_c_n_i,
  input  wire logic               rd_i,
  input  wire logic               wr_i,
  input  wire logic [7:0]         host_data_i,
  output logic      [7:0]         host_data_o,
  output logic                    host_data_oe_o,
  output logic                    read_driver_disable_o,
  output logic                    irq_out_o,
  output logic                    rx_dma_request_o,
  output logic                    tx_dma_request_o,
  output logic                    tx_x16_clock_out_o,
  input  wire logic               rx_x16_clock_i,
  input  wire logic               serial_in_i,
  output logic                    serial_out_o,
  input  wire uart_pkg::modem_in_t modem_i,
  output logic                    rts_n_o,
  output logic                    dtr_n_o
);
  import uart_pkg::*;
  localparam int PW = $clog2(DEPTH);

  // Wraps a FIFO pointer.
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  sel_t                sel_in, sel_eff, sel_r, sel_nxt;
  logic                cs_ok, rd_q_r, wr_q_r, rd_p, wr_p, dlab;
  logic [15:0]         div_r, div_nxt, bcnt_r, bcnt_nxt;
  logic                btick_r, btick_nxt, rxq_r, rx_tick;
  logic [3:0]          ien_r, ien_nxt, dlt_r, dlt_nxt;
  logic [7:0]          lctl_r, lctl_nxt, scr_r, scr_nxt, rdat_r, rdat_nxt;
  logic [1:0]          mctl_r, mctl_nxt;
  logic                fen_r, fen_nxt, oe_r, oe_nxt, thp_r, thp_nxt, irq_r, irq_nxt;
  modem_in_t           mprev_r;
  logic [7:0]          mstat;
  logic [7:0]          tx_mem [DEPTH];
  rx_entry_t           rx_mem [DEPTH];
  logic [PW-1:0]       twp_r, twp_nxt, trp_r, trp_nxt, rwp_r, rwp_nxt, rrp_r, rrp_nxt;
  logic [PW:0]         tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt, cap;
  logic                tpush, tpop, rpush, rpop, tclr, rclr;
  tx_state_t           ts_r, ts_nxt;
  logic [9:0]          tsh_r, tsh_nxt;
  logic [3:0]          tph_r, tph_nxt, tbit_r, tbit_nxt;
  rx_state_t           rs_r, rs_nxt;
  logic [3:0]          rph_r, rph_nxt, rbit_r, rbit_nxt;
  logic [7:0]          rsh_r, rsh_nxt;
  rx_entry_t           rent, rhead;
  logic [3:0]          iid;
  logic                ls_i, rda_i, thr_i, ms_i;

  // Selects pass through while the strobe is low and are held while it is high.
  assign sel_in  = '{chip_sel_a_i, chip_sel_b_i, chip_sel_c_n_i, reg_select_i};
  assign sel_eff = addr_strobe_n_i ? sel_r : sel_in;
  assign sel_nxt = addr_strobe_n_i ? sel_r : sel_in;
  assign cs_ok   = sel_eff.cs_a & sel_eff.cs_b & ~sel_eff.cs_c_n;
  assign rd_p    = rd_i & ~rd_q_r & cs_ok;
  assign wr_p    = wr_i & ~wr_q_r & cs_ok;
  assign dlab    = lctl_r[`LCTL_DLAB];
  assign rx_tick = rx_x16_clock_i & ~rxq_r;

  // Head entry, capacity and interrupt sources.
  assign rhead = rx_mem[rrp_r];
  assign cap   = fen_r ? (PW+1)'(DEPTH) : (PW+1)'(1);
  assign mstat = {~modem_i.dcd_n, 1'b0, ~modem_i.dsr_n, ~modem_i.cts_n, dlt_r};
  assign ls_i  = ien_r[`IEN_LS] & (oe_r | ((rcnt_r != '0) & (rhead.err != '0)));
  assign rda_i = ien_r[`IEN_RDA] & (rcnt_r != '0);
  assign thr_i = ien_r[`IEN_THRE] & thp_r;
  assign ms_i  = ien_r[`IEN_MS] & (dlt_r != '0);
  assign iid   = ls_i ? `IID_LS : rda_i ? `IID_RDA : thr_i ? `IID_THRE :
                 ms_i ? `IID_MS : `IID_NONE;

  // Host-side register file, modem change flags and interrupt.
  always_comb begin
    div_nxt  = div_r;
    ien_nxt  = ien_r;
    lctl_nxt = lctl_r;
    mctl_nxt = mctl_r;
    scr_nxt  = scr_r;
    fen_nxt  = fen_r;
    rdat_nxt = rdat_r;
    tpush = 1'b0;
    rpop  = 1'b0;
    tclr  = 1'b0;
    rclr  = 1'b0;
    if (wr_p) begin
      case (sel_eff.addr)
        `OFS_DATA: if (dlab) div_nxt[7:0] = host_data_i;
                   else tpush = (tcnt_r < cap);
        `OFS_IEN:  if (dlab) div_nxt[15:8] = host_data_i;
                   else ien_nxt = host_data_i[3:0];
        `OFS_IID: begin
          fen_nxt = host_data_i[`FCTL_EN];
          tclr = host_data_i[`FCTL_TXCLR] | (fen_nxt != fen_r);
          rclr = host_data_i[`FCTL_RXCLR] | (fen_nxt != fen_r);
        end
        `OFS_LCTL:    lctl_nxt = host_data_i;
        `OFS_MCTL:    mctl_nxt = host_data_i[1:0];
        `OFS_SCRATCH: scr_nxt = host_data_i;
        default: ;
      endcase
    end
    if (rd_p) begin
      case (sel_eff.addr)
        `OFS_DATA: begin
          rdat_nxt = dlab ? div_r[7:0] : rhead.data;
          rpop = ~dlab & (rcnt_r != '0);
        end
        `OFS_IEN:     rdat_nxt = dlab ? div_r[15:8] : {4'h0, ien_r};
        `OFS_IID:     rdat_nxt = {fen_r, fen_r, 2'b00, iid};
        `OFS_LCTL:    rdat_nxt = lctl_r;
        `OFS_MCTL:    rdat_nxt = {6'h00, mctl_r};
        `OFS_LSTAT:   rdat_nxt = {fen_r & (rhead.err != '0) & (rcnt_r != '0),
                                  (tcnt_r == '0) & (ts_r == TX_IDLE), tcnt_r == '0,
                                  rhead.err[2:1] & {2{rcnt_r != '0}}, 1'b0, oe_r,
                                  rcnt_r != '0};
        `OFS_MSTAT:   rdat_nxt = mstat;
        `OFS_SCRATCH: rdat_nxt = scr_r;
        default:      rdat_nxt = 8'h00;
      endcase
    end
    // Change flags: a new change wins over the clearing read.
    dlt_nxt = ((rd_p && sel_eff.addr == `OFS_MSTAT) ? 4'h0 : dlt_r) |
              {modem_i.dcd_n ^ mprev_r.dcd_n, 1'b0, modem_i.dsr_n ^ mprev_r.dsr_n,
               modem_i.cts_n ^ mprev_r.cts_n};
    oe_nxt  = ((rd_p && sel_eff.addr == `OFS_LSTAT) ? 1'b0 : oe_r) |
              (rpush & (rcnt_r >= cap));
    thp_nxt = ((tpush | (rd_p && sel_eff.addr == `OFS_IID && iid == `IID_THRE)) ? 1'b0 : thp_r)
              | (tpop & (tcnt_r == (PW+1)'(1)));
    irq_nxt = ls_i | rda_i | thr_i | ms_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sel_r   <= '0;
      rd_q_r  <= 1'b0;
      wr_q_r  <= 1'b0;
      div_r   <= `DIV_RST;
      ien_r   <= 4'h0;
      lctl_r  <= 8'h00;
      mctl_r  <= 2'h0;
      scr_r   <= 8'h00;
      fen_r   <= 1'b0;
      rdat_r  <= 8'h00;
      dlt_r   <= 4'h0;
      mprev_r <= '{1'b1, 1'b1, 1'b1};
      oe_r    <= 1'b0;
      thp_r   <= 1'b0;
      irq_r   <= 1'b0;
      rxq_r   <= 1'b0;
    end else begin
      sel_r   <= sel_nxt;
      rd_q_r  <= rd_i;
      wr_q_r  <= wr_i;
      div_r   <= div_nxt;
      ien_r   <= ien_nxt;
      lctl_r  <= lctl_nxt;
      mctl_r  <= mctl_nxt;
      scr_r   <= scr_nxt;
      fen_r   <= fen_nxt;
      rdat_r  <= rdat_nxt;
      dlt_r   <= dlt_nxt;
      mprev_r <= modem_i;
      oe_r    <= oe_nxt;
      thp_r   <= thp_nxt;
      irq_r   <= irq_nxt;
      rxq_r   <= rx_x16_clock_i;
    end
  end

  // Baud generator: one tick every divisor cycles; zero acts as one.
  always_comb begin
    bcnt_nxt  = (bcnt_r <= 16'h0001) ? div_r : bcnt_r - 16'h0001;
    btick_nxt = (bcnt_r <= 16'h0001);
  end

  // FIFO pointers and the transmit and receive engines.
  always_comb begin
    tpop = 1'b0; rpush = 1'b0;
    ts_nxt = ts_r; tsh_nxt = tsh_r; tph_nxt = tph_r; tbit_nxt = tbit_r;
    rs_nxt = rs_r; rph_nxt = rph_r; rbit_nxt = rbit_r; rsh_nxt = rsh_r;
    rent = '{3'b000, rsh_r};
    case (ts_r)
      TX_IDLE: if (btick_r && tcnt_r != '0) begin
        tpop = 1'b1;
        tsh_nxt = {1'b1, tx_mem[trp_r], 1'b0};
        tph_nxt = 4'h0;
        tbit_nxt = 4'h0;
        ts_nxt = TX_BUSY;
      end
      TX_BUSY: if (btick_r) begin
        tph_nxt = tph_r + 4'h1;
        if (tph_r == `OVS_LAST) begin
          tsh_nxt = {1'b1, tsh_r[9:1]};
          tbit_nxt = tbit_r + 4'h1;
          if (tbit_r == 4'h9) ts_nxt = TX_IDLE;
        end
      end
      default: ts_nxt = TX_IDLE;
    endcase
    case (rs_r)
      RX_IDLE: if (!serial_in_i) begin
        rs_nxt = RX_START;
        rph_nxt = 4'h0;
      end
      RX_START: if (rx_tick) begin
        rph_nxt = rph_r + 4'h1;
        if (rph_r == `OVS_MID) begin
          rs_nxt = serial_in_i ? RX_IDLE : RX_DATA;
          rph_nxt = 4'h0;
          rbit_nxt = 4'h0;
        end
      end
      RX_DATA: if (rx_tick) begin
        rph_nxt = rph_r + 4'h1;
        if (rph_r == `OVS_LAST) begin
          rsh_nxt = {serial_in_i, rsh_r[7:1]};
          rbit_nxt = rbit_r + 4'h1;
          if (rbit_r == 4'h7) rs_nxt = RX_STOP;
        end
      end
      RX_STOP: if (rx_tick && rph_r == `OVS_LAST) begin
        rpush = 1'b1;
        rent.err = {~serial_in_i & (rsh_r == 8'h00), ~serial_in_i, 1'b0};
        rs_nxt = RX_IDLE;
      end else if (rx_tick) rph_nxt = rph_r + 4'h1;
      default: rs_nxt = RX_IDLE;
    endcase
    twp_nxt  = tclr ? '0 : tpush ? ptr_inc(twp_r) : twp_r;
    trp_nxt  = tclr ? '0 : tpop ? ptr_inc(trp_r) : trp_r;
    tcnt_nxt = tclr ? '0 : tcnt_r + (PW+1)'(tpush) - (PW+1)'(tpop);
    rwp_nxt  = rclr ? '0 : (rpush && rcnt_r < cap) ? ptr_inc(rwp_r) : rwp_r;
    rrp_nxt  = rclr ? '0 : rpop ? ptr_inc(rrp_r) : rrp_r;
    rcnt_nxt = rclr ? '0 : rcnt_r + (PW+1)'(rpush && rcnt_r < cap) - (PW+1)'(rpop);
  end

  always_ff @(posedge mclk_i) begin
    if (tpush) tx_mem[twp_r] <= host_data_i;
    if (rpush && rcnt_r < cap) rx_mem[rwp_r] <= rent;
    if (sys_rst_i) begin
      bcnt_r <= `DIV_RST; btick_r <= 1'b0;
      twp_r <= '0; trp_r <= '0; tcnt_r <= '0;
      rwp_r <= '0; rrp_r <= '0; rcnt_r <= '0;
      ts_r <= TX_IDLE; tsh_r <= 10'h3FF; tph_r <= 4'h0; tbit_r <= 4'h0;
      rs_r <= RX_IDLE; rph_r <= 4'h0; rbit_r <= 4'h0; rsh_r <= 8'h00;
    end else begin
      bcnt_r <= bcnt_nxt; btick_r <= btick_nxt;
      twp_r <= twp_nxt; trp_r <= trp_nxt; tcnt_r <= tcnt_nxt;
      rwp_r <= rwp_nxt; rrp_r <= rrp_nxt; rcnt_r <= rcnt_nxt;
      ts_r <= ts_nxt; tsh_r <= tsh_nxt; tph_r <= tph_nxt; tbit_r <= tbit_nxt;
      rs_r <= rs_nxt; rph_r <= rph_nxt; rbit_r <= rbit_nxt; rsh_r <= rsh_nxt;
    end
  end

  // Pin outputs.
  assign host_data_o           = rdat_r;
  assign host_data_oe_o        = rd_i & rd_q_r & cs_ok;
  assign read_driver_disable_o = ~(rd_i & cs_ok);
  assign irq_out_o             = irq_r;
  assign rx_dma_request_o      = (rcnt_r != '0);
  assign tx_dma_request_o      = (tcnt_r < cap);
  assign tx_x16_clock_out_o    = btick_r;
  assign serial_out_o          = tsh_r[0] | (ts_r == TX_IDLE);
  assign rts_n_o               = ~mctl_r[1];
  assign dtr_n_o               = ~mctl_r[0];

  // Checks on the design's own behaviour.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_msr_read;
    rd_p && sel_eff.addr == `OFS_MSTAT;
  endsequence
  sequence s_tx_launch;
    ts_r == TX_IDLE && btick_r && tcnt_r != '0;
  endsequence
  a_char_mode_cap: assert property (!fen_r |-> tcnt_r <= 1 && rcnt_r <= 1)
    else $error("character mode holds more than one byte");
  a_fifo_cap: assert property (tcnt_r <= DEPTH && rcnt_r <= DEPTH)
    else $error("FIFO count above depth");
  a_rx_dma_req: assert property (rpop && rcnt_r == 1 && !rpush |=> !rx_dma_request_o)
    else $error("receive request stays after last byte");
  a_tx_start_bit: assert property (s_tx_launch |=> !serial_out_o [*1] ##1 1)
    else $error("start bit not driven low");
  a_baud_gap: assert property (btick_r && div_r > 16'h0001 && $stable(div_r) |=> !btick_r)
    else $error("baud tick too early");
  a_sel_hold: assert property (addr_strobe_n_i && $past(addr_strobe_n_i) |-> $stable(sel_r))
    else $error("held select changed");
  a_cs_gate: assert property (!cs_ok |-> !host_data_oe_o ##1 ($stable(scr_r) && $stable(lctl_r)))
    else $error("access while deselected");
  a_bus_drive: assert property (host_data_oe_o |-> !read_driver_disable_o)
    else $error("bus driven with driver disabled");
  a_cts_delta: assert property ($changed(modem_i.cts_n) |=> dlt_r[0])
    else $error("CTS change not flagged");
  a_dcd_read: assert property (s_msr_read |=> rdat_r[`MS_DCD] == ~$past(modem_i.dcd_n))
    else $error("DCD status wrong");
  a_read_driver_disable_idle: assert property (!rd_i |-> read_driver_disable_o)
    else $error("driver disable low outside read");
  a_dsr_delta: assert property ($changed(modem_i.dsr_n) |=> dlt_r[1])
    else $error("DSR change not flagged");
  a_ms_irq: assert property (ien_r[`IEN_MS] && dlt_r != '0 |=> irq_out_o)
    else $error("modem interrupt missing");
  a_msr_clear: assert property (s_msr_read ##0 $stable(modem_i) |=> dlt_r == 4'h0)
    else $error("change flags not cleared by read");
endmodule // uart_fifo_host_modem_port

// *** testbench/serial_peer.sv ***
// Far-side model: a data set that drives the serial input and modem lines and decodes output.
module serial_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic                mclk_i,
  input  wire logic                line_i,
  output logic                     line_o,
  output uart_pkg::modem_in_t      modem_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic [7:0] got_q [$];

  // The line idles high and every modem input starts inactive.
  initial begin
    line_o  = 1'b1;
    modem_o = 3'b111;
  end

  // Sends one frame: start bit, eight bits LSB first, one stop bit.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_i);
      line_o = fr[i];
      repeat (BIT_CYC - 1) @(negedge mclk_i);
    end
  endtask

  // Changes the modem inputs just after a falling edge.
  task automatic set_modem(input modem_in_t v);
    @(negedge mclk_i);
    modem_o = v;
  endtask

  // Samples each outgoing bit at its middle and queues bytes with a good stop bit.
  always begin
    logic [7:0] b;
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge mclk_i);
    if (line_i === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk_i);
        b[i] = line_i;
      end
      repeat (BIT_CYC) @(posedge mclk_i);
      if (line_i === 1'b1) begin
        got_q.push_back(b);
      end
    end
  end
endmodule // serial_peer

// *** testbench/uart_fifo_host_modem_port_bench.sv ***
// Bench for the serial port: register pin tasks, modem changes and serial traffic.
`include "uart_consts.svh"
module uart_fifo_host_modem_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic       mclk_i;
  logic       sys_rst_i = 1'b1;
  logic [2:0] reg_sel   = 3'h0;
  logic       strobe_n  = 1'b0;
  logic [2:0] cs_v      = 3'b110;
  logic       rd        = 1'b0;
  logic       wr        = 1'b0;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] rdata;
  logic       oe, drv_dis, irq, rxreq, txreq, x16, ser_in, ser_out, rts_n, dtr_n;
  modem_in_t  modem;
  int         mismatches = 0;
  int         n_checks   = 0;
  int         cycles     = 0;
  modem_in_t  mdm [4]     = '{3'b011, 3'b001, 3'b000, 3'b111};
  logic [7:0] msr_exp [4] = '{8'h11, 8'h32, 8'hB8, 8'h0B};
  logic [7:0] txb [3]     = '{8'hA5, 8'h5A, 8'h96};

  uart_fifo_host_modem_port u_uart_fifo_host_modem_port (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_select_i(reg_sel),
    .addr_strobe_n_i(strobe_n), .chip_sel_a_i(cs_v[2]), .chip_sel_b_i(cs_v[1]),
    .chip_sel_c_n_i(cs_v[0]), .rd_i(rd), .wr_i(wr), .host_data_i(wdata),
    .host_data_o(rdata), .host_data_oe_o(oe), .read_driver_disable_o(drv_dis),
    .irq_out_o(irq), .rx_dma_request_o(rxreq), .tx_dma_request_o(txreq),
    .tx_x16_clock_out_o(x16), .rx_x16_clock_i(x16), .serial_in_i(ser_in),
    .serial_out_o(ser_out), .modem_i(modem), .rts_n_o(rts_n), .dtr_n_o(dtr_n));

  serial_peer u_serial_peer (.mclk_i(mclk_i), .line_i(ser_out), .line_o(ser_in), .modem_o(modem));

  // Free-running 125 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: select and data set after a falling edge, held through the rising edge of wr.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_sel = a;
    wdata   = d;
    wr      = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
    @(negedge mclk_i);
  endtask

  // Read: data and bus enable are taken on the second cycle of rd, then rd is released.
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    logic sel_ok;
    sel_ok = (cs_v == 3'b110);
    @(negedge mclk_i);
    reg_sel = a;
    rd      = 1'b1;
    repeat (2) @(negedge mclk_i);
    d = rdata;
    check("oe", {7'h00, oe}, {7'h00, sel_ok});
    check("drv_dis", {7'h00, drv_dis}, {7'h00, ~sel_ok});
    rd = 1'b0;
    @(negedge mclk_i);
    check("drv_dis idle", {7'h00, drv_dis}, 8'h01);
    check("oe idle", {7'h00, oe}, 8'h00);
  endtask

  // Waits for a count of decoded bytes, then one more frame to see that no extra byte comes.
  task automatic wait_bytes(input int cnt);
    int n;
    n = 0;
    while (u_serial_peer.got_q.size() < cnt && n < 1500) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (400) @(negedge mclk_i);
    check("byte count", 8'(u_serial_peer.got_q.size()), 8'(cnt));
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short well above the expected run length.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict;
    end
  end

  // Main sequence of tests.
  initial begin
    logic [7:0] v;
    int         n;
    repeat (10) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    check("irq", {7'h00, irq}, 8'h00);
    check("tx req", {7'h00, txreq}, 8'h01);
    check("rx req", {7'h00, rxreq}, 8'h00);
    check("ser_out", {7'h00, ser_out}, 8'h01);
    check("drv_dis", {7'h00, drv_dis}, 8'h01);
    reg_rd(`OFS_IID, v);
    check("iid", v, 8'h01);
    $display("test reset done");
    for (int d = 3; d >= 2; d--) begin
      reg_wr(`OFS_LCTL, 8'h80);
      reg_wr(`OFS_DATA, 8'(d));
      reg_wr(`OFS_IEN, 8'h00);
      reg_wr(`OFS_LCTL, 8'h03);
      n = 0;
      while (x16 !== 1'b1 && n < 20) begin
        @(negedge mclk_i);
        n++;
      end
      n = 0;
      do begin
        @(negedge mclk_i);
        n++;
      end while (x16 !== 1'b1 && n < 20);
      check("baud period", 8'(n), 8'(d));
    end
    $display("test baud done");
    reg_wr(`OFS_IEN, 8'h08);
    reg_rd(`OFS_MSTAT, v);
    check("msr", v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_serial_peer.set_modem(mdm[i]);
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
        @(negedge mclk_i);
        n++;
      end
      check("irq set", {7'h00, irq}, 8'h01);
      reg_rd(`OFS_MSTAT, v);
      check("msr", v, msr_exp[i]);
      check("irq clear", {7'h00, irq}, 8'h00);
    end
    reg_rd(`OFS_MSTAT, v);
    check("msr reread", v, 8'h00);
    reg_wr(`OFS_IEN, 8'h00);
    $display("test modem done");
    reg_wr(`OFS_SCRATCH, 8'h5A);
    for (int i = 0; i < 3; i++) begin
      cs_v = (i == 0) ? 3'b010 : ((i == 1) ? 3'b100 : 3'b111);
      reg_wr(`OFS_SCRATCH, 8'hFF);
      reg_rd(`OFS_SCRATCH, v);
      cs_v = 3'b110;
      reg_rd(`OFS_SCRATCH, v);
      check("scratch", v, 8'h5A);
    end
    // Modem control bits written over the bus drive the RTS and DTR pins.
    reg_wr(`OFS_MCTL, 8'h02);
    check("rts_n", {7'h00, rts_n}, 8'h00);
    check("dtr_n", {7'h00, dtr_n}, 8'h01);
    reg_rd(`OFS_MCTL, v);
    check("mctl", v, 8'h02);
    @(negedge mclk_i);
    reg_sel = 3'h7;
    @(negedge mclk_i);
    strobe_n = 1'b1;
    cs_v     = 3'b000;
    reg_wr(`OFS_DATA, 8'hC7);
    @(negedge mclk_i);
    strobe_n = 1'b0;
    cs_v     = 3'b110;
    reg_rd(`OFS_SCRATCH, v);
    check("latched select", v, 8'hC7);
    $display("test select done");
    for (int i = 0; i < 3; i++) begin
      reg_wr(`OFS_DATA, txb[i]);
    end
    check("tx req full", {7'h00, txreq}, 8'h00);
    wait_bytes(2);
    check("tx0", u_serial_peer.got_q[0], 8'hA5);
    check("tx1", u_serial_peer.got_q[1], 8'h5A);
    u_serial_peer.got_q.delete();
    reg_wr(`OFS_IID, 8'h01);
    reg_rd(`OFS_IID, v);
    check("iid fifo", v, 8'hC1);
    for (int i = 0; i < 3; i++) begin
      reg_wr(`OFS_DATA, txb[i]);
    end
    reg_wr(`OFS_IEN, 8'h02);
    wait_bytes(3);
    for (int i = 0; i < 3; i++) begin
      check("fifo tx", u_serial_peer.got_q[i], txb[i]);
    end
    // The last byte leaving the store raises the empty interrupt; reading its code clears it.
    check("irq thre", {7'h00, irq}, 8'h01);
    reg_rd(`OFS_IID, v);
    check("iid thre", v, 8'hC2);
    check("irq thre clear", {7'h00, irq}, 8'h00);
    reg_wr(`OFS_IEN, 8'h00);
    $display("test transmit done");
    reg_wr(`OFS_IEN, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_serial_peer.send_byte(~txb[i]);
    end
    check("rx req", {7'h00, rxreq}, 8'h01);
    check("irq rda", {7'h00, irq}, 8'h01);
    reg_rd(`OFS_IID, v);
    check("iid rda", v, 8'hC4);
    for (int i = 0; i < 3; i++) begin
      reg_rd(`OFS_DATA, v);
      check("fifo rx", v, ~txb[i]);
    end
    check("rx req empty", {7'h00, rxreq}, 8'h00);
    check("irq rda clear", {7'h00, irq}, 8'h00);
    reg_wr(`OFS_IEN, 8'h00);
    reg_wr(`OFS_IID, 8'h00);
    reg_rd(`OFS_IID, v);
    check("iid char", v, 8'h01);
    u_serial_peer.send_byte(8'h3C);
    u_serial_peer.send_byte(8'hC3);
    reg_rd(`OFS_LSTAT, v);
    check("lsr overrun", v & 8'h03, 8'h03);
    reg_rd(`OFS_DATA, v);
    check("char rx", v, 8'h3C);
    reg_rd(`OFS_LSTAT, v);
    check("lsr ready", v & 8'h01, 8'h00);
    $display("test receive done");
    print_verdict;
  end
endmodule // uart_fifo_host_modem_port_bench
